// file: bench/ulc_peer.sv
`timescale 1ns/1ns
// Remote serial node, 16 clocks per bit like the device
module ulc_peer
    import ulc_pkg::*;
(
    input wire logic clk,
    input wire logic inv,
    input wire logic line_in,
    output logic line_out
);
    localparam int BC = 16;
    logic q = 1'b1;
    logic lvl;
    // Pin inversion on the peer side mirrors the device setting
    assign lvl = line_in ^ inv;
    assign line_out = q ^ inv;

    // Wait for a start bit, bounded so a silent line cannot hang
    task automatic wait_start();
        int w;
        w = 0;
        while (lvl !== 1'b0 && w < 4000) begin
            @(posedge clk);
            w++;
        end
    endtask

    // Sample at mid bit, first wire bit lands in bit 0
    task automatic recv(output logic [7:0] b);
        wait_start();
        repeat (BC / 2) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            repeat (BC) @(posedge clk);
            b[i] = lvl;
        end
    endtask

    // One start, eight data bits, one stop, then idle high
    task automatic send(input logic [7:0] b);
        @(posedge clk);
        q <= 1'b0;
        repeat (BC) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            q <= b[i];
            repeat (BC) @(posedge clk);
        end
        q <= 1'b1;
        repeat (BC) @(posedge clk);
    endtask

    // Low stretch given in half bits, to probe break thresholds
    task automatic brk(input int halves);
        @(posedge clk);
        q <= 1'b0;
        repeat (halves * BC / 2) @(posedge clk);
        q <= 1'b1;
    endtask

    // Clocks that the device holds its line low
    task automatic low_len(output int n);
        wait_start();
        n = 0;
        while (lvl === 1'b0 && n < 4000) begin
            @(posedge clk);
            n++;
        end
    endtask
endmodule

// file: bench/ulc_top_tb_top.sv
`timescale 1ns/1ns
module ulc_top_tb_top;
    import ulc_pkg::*;
    // Unit, receiver, transmitter and match use on
    localparam logic [31:0] C1_RUN = 32'h0000_400D;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic swap_cab = 1'b0;
    logic peer_inv = 1'b0;
    logic [31:0] rdata;
    logic pin_a_out, pin_a_oe, pin_b_out, pin_b_oe;
    logic sync_clk_pin, sync_clk_oe, lin_break_irq;
    logic pin_a_in, pin_b_in, wire_a, wire_b, dev_tx, peer_tx;
    logic [7:0] got;
    int n_mismatch = 0;
    int checks = 0;
    int ck_edges = 0;
    int n;
    logic [31:0] row_c2 [6] = '{32'h0000_0000, 32'h0008_0000, 32'h0004_0000,
        32'h0003_0000, 32'h0000_8000, 32'h000C_0000};
    logic [7:0] row_exp [6] = '{8'hA3, 8'hC5, 8'h5C, 8'hA3, 8'hA3, 8'h3A};

    always #50 clk = ~clk;
    always @(posedge sync_clk_pin) ck_edges++;

    // Pull-ups on both pins; the cable crossing follows the swap setting
    assign wire_a = pin_a_oe ? pin_a_out : 1'b1;
    assign wire_b = pin_b_oe ? pin_b_out : 1'b1;
    assign dev_tx = swap_cab ? wire_b : wire_a;
    assign pin_a_in = swap_cab ? peer_tx : wire_a;
    assign pin_b_in = swap_cab ? wire_b : peer_tx;

    ulc_top u_dut (
        .clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .pin_a_in(pin_a_in), .pin_b_in(pin_b_in),
        .pin_a_out(pin_a_out), .pin_a_oe(pin_a_oe), .pin_b_out(pin_b_out),
        .pin_b_oe(pin_b_oe), .sync_clk_pin(sync_clk_pin),
        .sync_clk_oe(sync_clk_oe), .lin_break_irq(lin_break_irq)
    );
    ulc_peer u_peer (.clk(clk), .inv(peer_inv), .line_in(dev_tx),
        .line_out(peer_tx));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic rchk(input logic [7:0] a, input logic [31:0] m,
        input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(rdata & m, e);
    endtask

    // Unit off, settings, then unit on
    task automatic cfg(input logic [31:0] c2, input logic [31:0] c1);
        wr_reg(ULC_OFS_CTRL1, 32'h0000_0000);
        wr_reg(ULC_OFS_CTRL2, c2);
        wr_reg(ULC_OFS_CTRL1, c1);
        repeat (3) @(posedge clk);
    endtask

    task automatic test_done();
        if (n_mismatch == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Whole run is near 4k clocks; over ten times that means a hang
    initial begin
        #5000000;
        n_mismatch++;
        test_done();
    end

    initial begin
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        chk({pin_a_out, pin_a_oe, sync_clk_oe, lin_break_irq}, 32'h8);
        rchk(ULC_OFS_CTRL2, 32'hFFFF_FFFF, 32'h0000_0000);
        wr_reg(ULC_OFS_CTRL2, 32'hFFFF_FFFF);
        rchk(ULC_OFS_CTRL2, 32'hFFFF_FFFF, 32'hFFFF_FF70);
        chk(sync_clk_oe, 32'h1);
        rchk(8'h40, 32'hFFFF_FFFF, 32'h0000_0000);
        // Each bit order, inversion and swap option both ways; match code set to the result
        for (int i = 0; i < 6; i++) begin
            cfg(row_c2[i] | {row_exp[i], 24'h0}, C1_RUN);
            swap_cab <= row_c2[i][ULC_SWAP_BIT];
            peer_inv <= row_c2[i][ULC_TINV_BIT];
            @(posedge clk);
            chk(dev_tx, {31'h0, ~peer_inv});
            chk(pin_b_oe, {31'h0, swap_cab});
            fork
                u_peer.recv(got);
                wr_reg(ULC_OFS_TXD, 32'h0000_00A3);
            join
            chk(got, row_exp[i]);
            u_peer.send(8'hA3);
            repeat (16) @(posedge clk);
            rchk(ULC_OFS_RXD, 32'hFF, row_exp[i]);
            rchk(ULC_OFS_STAT, 32'h1, 32'h1);
        end
        swap_cab <= 1'b0;
        peer_inv <= 1'b0;
        // Idle level, then pulse count with and without the last pulse
        for (int k = 0; k < 2; k++) begin
            cfg(32'h0000_0800 | (k * 32'h0000_0500), C1_RUN);
            chk(sync_clk_pin, k);
            chk(sync_clk_oe, 32'h1);
            ck_edges = 0;
            fork
                u_peer.recv(got);
                wr_reg(ULC_OFS_TXD, 32'h0000_005A);
            join
            repeat (16) @(posedge clk);
            chk(ck_edges, 7 + k);
        end
        cfg(32'h0000_4040, C1_RUN);
        fork
            u_peer.low_len(n);
            wr_reg(ULC_OFS_REQ, 32'h0000_0001);
        join
        chk(n, 13 * 16);
        // Break just over ten bits at the 10 and 11 bit settings, then just over eleven
        for (int j = 0; j < 3; j++) begin
            cfg(32'h0000_4040 | ((j > 0) ? 32'h20 : 32'h0), C1_RUN);
            u_peer.brk((j == 2) ? 23 : 21);
            repeat (32) @(posedge clk);
            chk(lin_break_irq, j != 1);
            rchk(ULC_OFS_STAT, 32'h4, (j != 1) ? 32'h4 : 32'h0);
        end
        // Every method measures a 16 clock last low time here
        for (int m = 0; m < 4; m++) begin
            cfg(32'h0010_0000 | (m << ULC_ABM_LSB), C1_RUN);
            u_peer.send((m == 2) ? 8'h7F : 8'h55);
            rchk(ULC_OFS_STAT, 32'h001F_FFE8, 32'h0000_0208);
        end
        wr_reg(ULC_OFS_TOVAL, 32'h0000_0002);
        cfg(32'h0080_0000, C1_RUN);
        u_peer.send(8'h3C);
        rchk(ULC_OFS_STAT, 32'h2, 32'h0);
        repeat (48) @(posedge clk);
        rchk(ULC_OFS_STAT, 32'h2, 32'h2);
        wr_reg(ULC_OFS_CTRL1, 32'h0000_0000);
        rchk(ULC_OFS_STAT, 32'h7, 32'h0);
        rchk(ULC_OFS_CTRL2, 32'hFFFF_FFFF, 32'h0080_0000);
        chk(pin_a_oe, 32'h0);
        test_done();
    end
endmodule

// file: hw/ulc_pkg.sv
// What this block does
// - Outside mute, compare each received 8-bit character with match code; set flag
// - With timeout enabled, flag set after line idle for programmed duration
// - Auto baud method: field stored but unused; every setting measures each low time on the receive line, keeping the last
// - Auto baud enable turns detection on; method written only while off
// - Bit order: clear sends bit 0 first, set sends MSB first
// - Data inversion sends and receives data bits inverted
// - Transmit pin inversion flips transmit pin level
// - Receive pin inversion flips receive pin interpretation
// - Pin swap exchanges transmit and receive pin functions
// - LIN mode sends 13-bit low break on request and detects breaks
// - Stop field: 00 one, 01 half, 10 two, 11 one and half
// - Clock output enable drives the sync clock pin, else pin disabled
// - Clock polarity sets clock pin idle level outside transmission
// - Clock phase picks first or second transition as capture edge
// - Final bit pulse decides if last data bit clock appears
// - LIN break interrupt raised while break flag set and enabled
// - Break detection length: 10 bits clear, 11 bits set
// - Address width: 4 or 7 bits in 8-bit mode
// - Unit disable releases data pins (sync clock pin stays under clock enable), drops operations, keeps config, clears flags
package ulc_pkg;
    localparam logic [7:0] ULC_OFS_CTRL2 = 8'h04;
    localparam logic [7:0] ULC_OFS_CTRL1 = 8'h00;
    localparam logic [7:0] ULC_OFS_STAT = 8'h08;
    localparam logic [7:0] ULC_OFS_TOVAL = 8'h0C;
    localparam logic [7:0] ULC_OFS_REQ = 8'h10;
    localparam logic [7:0] ULC_OFS_TXD = 8'h14;
    localparam logic [7:0] ULC_OFS_RXD = 8'h18;
    localparam logic [31:0] ULC_CTRL2_RST = 32'h0000_0000;
    localparam logic [31:0] ULC_CTRL2_MASK = 32'hFFFF_FF70;
    localparam int ULC_ADD_LSB = 24;
    localparam int ULC_RTO_BIT = 23;
    localparam int ULC_ABM_LSB = 21;
    localparam int ULC_ABE_BIT = 20;
    localparam int ULC_MSB_BIT = 19;
    localparam int ULC_DINV_BIT = 18;
    localparam int ULC_TINV_BIT = 17;
    localparam int ULC_RINV_BIT = 16;
    localparam int ULC_SWAP_BIT = 15;
    localparam int ULC_LIN_BIT = 14;
    localparam int ULC_STOP_LSB = 12;
    localparam int ULC_CKEN_BIT = 11;
    localparam int ULC_SYNC_CLK_IDLE_LEVEL_BIT = 10;
    localparam int ULC_SYNC_CLK_CAPTURE_EDGE_BIT = 9;
    localparam int ULC_FINAL_BIT_PULSE_BIT = 8;
    localparam int ULC_LBIE_BIT = 6;
    localparam int ULC_LIN_BREAK_LENGTH_BIT = 5;
    localparam int ULC_AW_BIT = 4;
    // Control 1 fields (own layout)
    localparam int ULC_UE_BIT = 0;
    localparam int ULC_RE_BIT = 2;
    localparam int ULC_TE_BIT = 3;
    localparam int ULC_MUTE_BIT = 13;
    localparam int ULC_CM_BIT = 14;
    // Status bits
    localparam int ULC_ST_CMF = 0;
    localparam int ULC_ST_RX_TIMEOUT_FLAG = 1;
    localparam int ULC_ST_LIN_BREAK_FLAG = 2;
    localparam int ULC_ST_ABRF = 3;
    localparam int ULC_ST_BUSY = 4;
    // Cycles per bit, own default: 16 at 10 MHz
    localparam logic [15:0] ULC_BIT_CYC = 16'h0010;
    localparam logic [3:0] ULC_BRK_BITS = 4'hD;
    localparam logic [3:0] ULC_DET10 = 4'hA;
    localparam logic [3:0] ULC_DET11 = 4'hB;

    typedef enum logic [2:0] {
        ULC_IDLE = 3'b000,
        ULC_START = 3'b001,
        ULC_DATA = 3'b010,
        ULC_STOP = 3'b011,
        ULC_BREAK = 3'b100
    } ulc_tx_t;

    typedef struct packed {
        logic tx;
        logic tx_oe;
        logic ck;
        logic ck_oe;
        logic irq;
    } ulc_pins_t;
endpackage

// file: hw/ulc_top.sv
`timescale 1ns/1ns
module ulc_top
    import ulc_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    input wire logic pin_a_in,
    input wire logic pin_b_in,
    output logic pin_a_out,
    output logic pin_a_oe,
    output logic pin_b_out,
    output logic pin_b_oe,
    output logic sync_clk_pin,
    output logic sync_clk_oe,
    output logic lin_break_irq
);
    typedef struct packed {
        logic [31:0] cr2;
        logic [15:0] cr1;
        logic [15:0] toval;
        logic [3:0] st;
        logic [31:0] rdata;
        logic [1:0] sa;
        logic [1:0] sb;
        ulc_tx_t tst;
        logic [15:0] tcnt;
        logic [3:0] tbit;
        logic [8:0] tsh;
        logic tline;
        logic tck;
        logic pin_a;
        logic pin_b;
        logic ckp;
        logic cko;
        logic irq;
        logic rprev;
        logic rbusy;
        logic [15:0] rcnt;
        logic [3:0] rbit;
        logic [7:0] rsh;
        logic [7:0] rxd;
        logic [15:0] idle;
        logic [3:0] lowbits;
        logic [15:0] lowcnt;
        logic [15:0] abr;
    } ulc_st_t;
    ulc_st_t q, d;
    logic ue, re, te, rx_line;
    logic [1:0] stopsel;
    logic [15:0] stop_cyc;
    logic [7:0] rx_char;

    // Bit reversal used on both data paths
    function automatic logic [7:0] rev8(input logic [7:0] v);
        for (int i = 0; i < 8; i++) begin
            rev8[i] = v[7-i];
        end
    endfunction

    // Stop length in cycles from the stop field
    function automatic logic [15:0] stop_len(input logic [1:0] s);
        case (s)
            2'b00: stop_len = ULC_BIT_CYC;
            2'b01: stop_len = ULC_BIT_CYC >> 1;
            2'b10: stop_len = ULC_BIT_CYC << 1;
            default: stop_len = ULC_BIT_CYC + (ULC_BIT_CYC >> 1);
        endcase
    endfunction

    // Whole character outside mute; 4 or 7 address bits in mute
    function automatic logic char_hit(input logic [7:0] c,
        input logic [7:0] code, input logic mute, input logic aw);
        if (!mute) begin
            char_hit = (c == code);
        end else if (aw) begin
            char_hit = (c[6:0] == code[6:0]);
        end else begin
            char_hit = (c[3:0] == code[3:0]);
        end
    endfunction

    assign ue = q.cr1[ULC_UE_BIT];
    assign re = q.cr1[ULC_RE_BIT];
    assign te = q.cr1[ULC_TE_BIT];
    assign stopsel = q.cr2[ULC_STOP_LSB+:2];
    assign stop_cyc = stop_len(stopsel);
    // Swapped pins take the other synchronised input
    assign rx_line = (q.cr2[ULC_SWAP_BIT] ? q.sa[1] : q.sb[1])
        ^ q.cr2[ULC_RINV_BIT];
    // Undo data inversion, then bit order
    assign rx_char = q.cr2[ULC_MSB_BIT] ?
        rev8(q.rsh ^ {8{q.cr2[ULC_DINV_BIT]}}) :
        (q.rsh ^ {8{q.cr2[ULC_DINV_BIT]}});

    // Next state of the whole block
    always_comb begin
        d = q;
        d.sa = {q.sa[0], pin_a_in};
        d.sb = {q.sb[0], pin_b_in};
        d.rdata = 32'h0000_0000;
        d.rprev = rx_line;
        // Register writes; software keeps the write windows
        if (wr) begin
            case (addr)
                ULC_OFS_CTRL2: d.cr2 = wdata & ULC_CTRL2_MASK;
                ULC_OFS_CTRL1: d.cr1 = wdata[15:0];
                ULC_OFS_TOVAL: d.toval = wdata[15:0];
                default: ;
            endcase
        end
        if (rd) begin
            case (addr)
                ULC_OFS_CTRL2: d.rdata = q.cr2;
                ULC_OFS_CTRL1: d.rdata = {16'h0000, q.cr1};
                ULC_OFS_TOVAL: d.rdata = {16'h0000, q.toval};
                ULC_OFS_STAT: d.rdata = {11'h000, q.abr,
                    q.tst != ULC_IDLE, q.st};
                ULC_OFS_RXD: d.rdata = {24'h000000, q.rxd};
                default: d.rdata = 32'h0000_0000;
            endcase
        end
        // Status clear by writing one to the status register
        if (wr && addr == ULC_OFS_STAT) begin
            d.st = q.st & ~wdata[3:0];
        end

        // Transmitter
        case (q.tst)
            ULC_IDLE: begin
                d.tline = 1'b1;
                d.tck = q.cr2[ULC_SYNC_CLK_IDLE_LEVEL_BIT];
                d.tcnt = 16'h0000;
                if (te && wr && addr == ULC_OFS_REQ && wdata[0]
                    && q.cr2[ULC_LIN_BIT]) begin
                    d.tst = ULC_BREAK;
                    d.tbit = 4'h0;
                end else if (te && wr && addr == ULC_OFS_TXD) begin
                    d.tsh = {1'b1, (q.cr2[ULC_MSB_BIT] ?
                        rev8(wdata[7:0]) : wdata[7:0])
                        ^ {8{q.cr2[ULC_DINV_BIT]}}};
                    d.tst = ULC_START;
                end
            end
            ULC_START: begin
                d.tline = 1'b0;
                d.tcnt = q.tcnt + 16'h0001;
                if (q.tcnt == ULC_BIT_CYC - 16'h0001) begin
                    d.tcnt = 16'h0000;
                    d.tbit = 4'h0;
                    d.tst = ULC_DATA;
                end
            end
            ULC_DATA: begin
                d.tline = q.tsh[0];
                d.tcnt = q.tcnt + 16'h0001;
                // Clock edge at mid or start of bit by phase
                if ((q.tbit != 4'h7) || q.cr2[ULC_FINAL_BIT_PULSE_BIT]) begin
                    d.tck = q.cr2[ULC_SYNC_CLK_IDLE_LEVEL_BIT] ^
                        ((q.tcnt < (ULC_BIT_CYC >> 1))
                        ^ q.cr2[ULC_SYNC_CLK_CAPTURE_EDGE_BIT]);
                end
                if (q.tcnt == ULC_BIT_CYC - 16'h0001) begin
                    d.tcnt = 16'h0000;
                    d.tsh = {1'b1, q.tsh[8:1]};
                    d.tbit = q.tbit + 4'h1;
                    if (q.tbit == 4'h7) begin
                        d.tst = ULC_STOP;
                    end
                end
            end
            ULC_STOP: begin
                d.tline = 1'b1;
                d.tck = q.cr2[ULC_SYNC_CLK_IDLE_LEVEL_BIT];
                d.tcnt = q.tcnt + 16'h0001;
                if (q.tcnt == stop_cyc - 16'h0001) begin
                    d.tst = ULC_IDLE;
                end
            end
            ULC_BREAK: begin
                d.tline = 1'b0;
                d.tcnt = q.tcnt + 16'h0001;
                if (q.tcnt == ULC_BIT_CYC - 16'h0001) begin
                    d.tcnt = 16'h0000;
                    d.tbit = q.tbit + 4'h1;
                    if (q.tbit == ULC_BRK_BITS - 4'h1) begin
                        d.tst = ULC_STOP;
                    end
                end
            end
            default: d.tst = ULC_IDLE;
        endcase

        // Receiver: sample mid bit after falling edge
        if (!q.rbusy) begin
            d.rcnt = 16'h0000;
            if (re && q.rprev && !rx_line) begin
                d.rbusy = 1'b1;
                d.rbit = 4'h0;
            end
        end else begin
            d.rcnt = q.rcnt + 16'h0001;
            if (q.rcnt == (ULC_BIT_CYC >> 1) + ULC_BIT_CYC) begin
                d.rcnt = 16'h0001 + (ULC_BIT_CYC >> 1);
                d.rbit = q.rbit + 4'h1;
                if (q.rbit == 4'h8) begin
                    d.rbusy = 1'b0;
                    d.rxd = rx_char;
                    // Character against match code: whole outside mute, 4 or 7 address bits in mute
                    if (q.cr1[ULC_CM_BIT] && char_hit(rx_char,
                        q.cr2[ULC_ADD_LSB+:8], q.cr1[ULC_MUTE_BIT],
                        q.cr2[ULC_AW_BIT])) begin
                        d.st[ULC_ST_CMF] = 1'b1;
                    end
                end else begin
                    d.rsh = {rx_line, q.rsh[7:1]};
                end
            end
        end

        // Idle timeout counted in bit times
        if (q.rbusy || !rx_line || !re) begin
            d.idle = 16'h0000;
        end else if (q.cr2[ULC_RTO_BIT] && q.rcnt == 16'h0000) begin
            if (q.idle != 16'hFFFF) begin
                d.idle = q.idle + 16'h0001;
            end
            if (q.idle == q.toval * ULC_BIT_CYC && q.toval != 16'h0000) begin
                d.st[ULC_ST_RX_TIMEOUT_FLAG] = 1'b1;
            end
        end

        // Low time for LIN break detection and auto baud measure
        if (rx_line) begin
            d.lowcnt = 16'h0000;
            d.lowbits = 4'h0;
            // Whole bits plus remainder, since lowcnt wraps each bit
            if (!q.rprev && q.cr2[ULC_ABE_BIT]
                && (q.lowcnt != 16'h0000 || q.lowbits != 4'h0)) begin
                d.abr = 16'({q.lowbits, 4'h0} * (ULC_BIT_CYC >> 4))
                    + q.lowcnt;
                d.st[ULC_ST_ABRF] = 1'b1;
            end
        end else begin
            d.lowcnt = q.lowcnt + 16'h0001;
            if (q.lowcnt == ULC_BIT_CYC - 16'h0001) begin
                d.lowcnt = 16'h0000;
                if (q.lowbits != 4'hF) begin
                    d.lowbits = q.lowbits + 4'h1;
                end
                if (q.cr2[ULC_LIN_BIT] && (q.lowbits + 4'h1) ==
                    (q.cr2[ULC_LIN_BREAK_LENGTH_BIT] ? ULC_DET11 : ULC_DET10)) begin
                    d.st[ULC_ST_LIN_BREAK_FLAG] = 1'b1;
                end
            end
        end

        // Pin outputs
        d.pin_a = q.tline ^ q.cr2[ULC_TINV_BIT];
        d.pin_b = d.pin_a;
        d.ckp = q.tck;
        d.cko = q.cr2[ULC_CKEN_BIT];
        d.irq = q.cr2[ULC_LBIE_BIT] & q.st[ULC_ST_LIN_BREAK_FLAG];

        // Unit off: stop and clear, keep configuration
        if (!ue) begin
            d.st = 4'h0;
            d.tst = ULC_IDLE;
            d.rbusy = 1'b0;
            d.idle = 16'h0000;
            d.lowbits = 4'h0;
            d.lowcnt = 16'h0000;
            d.tline = 1'b1;
            d.tck = q.cr2[ULC_SYNC_CLK_IDLE_LEVEL_BIT];
            d.irq = 1'b0;
        end
    end

    // State register
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            q <= '0;
            q.tst <= ULC_IDLE;
            q.tline <= 1'b1;
            q.pin_a <= 1'b1;
            q.pin_b <= 1'b1;
            q.rprev <= 1'b1;
            q.sa <= 2'b11;
            q.sb <= 2'b11;
        end else begin
            q <= d;
        end
    end

    // Swap picks which pin drives
    assign rdata = q.rdata;
    assign pin_a_out = q.pin_a;
    assign pin_b_out = q.pin_b;
    assign pin_a_oe = ue & ~q.cr2[ULC_SWAP_BIT];
    assign pin_b_oe = ue & q.cr2[ULC_SWAP_BIT];
    assign sync_clk_pin = q.ckp;
    assign sync_clk_oe = q.cko;
    assign lin_break_irq = q.irq;

    property p_reserved;
        @(posedge clk) disable iff (!reset_n)
        wr && addr == ULC_OFS_CTRL2 |=> (q.cr2 & ~ULC_CTRL2_MASK) == 0;
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("reserved bits set");
    property p_irq;
        @(posedge clk) disable iff (!reset_n)
        ue && q.cr2[ULC_LBIE_BIT] && q.st[ULC_ST_LIN_BREAK_FLAG] |=> lin_break_irq;
    endproperty
    a_irq: assert property (p_irq)
        else $error("break irq missing");
    property p_ueoff;
        @(posedge clk) disable iff (!reset_n)
        !ue |=> q.st == 4'h0 && q.tst == ULC_IDLE;
    endproperty
    a_ueoff: assert property (p_ueoff)
        else $error("unit off not cleared");
    property p_ckoe;
        @(posedge clk) disable iff (!reset_n)
        ##1 sync_clk_oe == $past(q.cr2[ULC_CKEN_BIT]);
    endproperty
    a_ckoe: assert property (p_ckoe)
        else $error("clock enable wrong");
    property p_sync_clk_idle_level;
        @(posedge clk) disable iff (!reset_n)
        q.tst == ULC_IDLE && $stable(q.cr2) ##1 q.tst == ULC_IDLE
            |=> sync_clk_pin == $past(q.cr2[ULC_SYNC_CLK_IDLE_LEVEL_BIT], 2);
    endproperty
    a_sync_clk_idle_level: assert property (p_sync_clk_idle_level)
        else $error("idle clock level wrong");
    property p_tx_level_invert;
        @(posedge clk) disable iff (!reset_n)
        ##1 pin_a_out == ($past(q.tline) ^ $past(q.cr2[ULC_TINV_BIT]));
    endproperty
    a_tx_level_invert: assert property (p_tx_level_invert)
        else $error("tx level wrong");
    property p_swap;
        @(posedge clk) disable iff (!reset_n)
        pin_a_oe |-> !pin_b_oe;
    endproperty
    a_swap: assert property (p_swap)
        else $error("both pins driven");
    property p_break;
        @(posedge clk) disable iff (!reset_n)
        q.tst == ULC_BREAK && q.tcnt == 16'h0000 && q.tbit == 4'h0
            |-> ##1 (!q.tline)[*8];
    endproperty
    a_break: assert property (p_break)
        else $error("break not low");
endmodule
